// >>> src/flash_prot_pkg.sv
// Constants and types for the flash block protection logic
//
// Contract
// - Flash of 256 KB is a row of 1 KB units, each erased alone.
// - A finished unit erase leaves every bit of that unit at one.
// - Protection is per 2 KB pair of erase units, each pair independent.
// - Each 2 KB pair can be set read-only or execute-only.
// - Read-only pairs refuse every erase and program request.
// - Execute-only pairs refuse every erase and program request.
// - Execute-only pairs return data to instruction fetch only, never data or debug.
package flash_prot_pkg;
	localparam int ADDR_W = 18;               // 256 KB byte address
	localparam int DATA_W = 32;
	localparam int WORD_W = ADDR_W - 2;        // word address width
	localparam int ERASE_UNIT_SH = 10;         // 1 KB erase unit
	localparam int PROT_UNIT_SH = 11;          // 2 KB protection pair
	localparam int N_ERASE = 256;
	localparam int N_PROT = 128;
	localparam int ERASE_IDX_W = ADDR_W - ERASE_UNIT_SH;
	localparam int PROT_IDX_W = ADDR_W - PROT_UNIT_SH;
	localparam int UNIT_WORDS = 256;           // words in one erase unit
	localparam int UNIT_WORD_W = 8;
	localparam logic [DATA_W-1:0] ERASED_WORD = 32'hFFFFFFFF;
	localparam logic [N_PROT-1:0] RO_RESET = '0;
	localparam logic [N_PROT-1:0] XO_RESET = '0;

	typedef enum logic [1:0] {
		OP_READ,
		OP_PROG,
		OP_ERASE
	} op_t;

	typedef enum logic [1:0] {
		SRC_FETCH,
		SRC_DATA,
		SRC_DEBUG
	} src_t;

	typedef enum {
		ST_IDLE,
		ST_ERASE
	} state_t;
endpackage : flash_prot_pkg

// >>> src/flash_block_protection.sv
// Flash array with per-pair protection, unit erase, and violation flag
`timescale 1ns/1ps
`default_nettype none
module flash_block_protection
	import flash_prot_pkg::*;
(
	input wire logic clk_sys_i,                 // System clock, 50 MHz
	input wire logic srst_i,                    // Synchronous reset, high
	input wire logic req_valid_i,               // Request strobe
	input wire logic [1:0] req_op_i,            // Operation code, op_t
	input wire logic [1:0] req_src_i,           // Requester, src_t
	input wire logic [ADDR_W-1:0] req_addr_i,   // Byte address
	input wire logic [DATA_W-1:0] req_wdata_i,  // Program data
	output logic req_ready_o,                   // Able to take a request
	output logic rsp_valid_o,                   // Request finished
	output logic rsp_denied_o,                  // Finished request was refused
	output logic [DATA_W-1:0] rsp_rdata_o,      // Read data, zero if refused
	input wire logic cfg_we_i,                  // Protection setting write
	input wire logic [PROT_IDX_W-1:0] cfg_idx_i,// Pair being set
	input wire logic cfg_ro_i,                  // Read-only setting
	input wire logic cfg_xo_i,                  // Execute-only setting
	output logic [N_PROT-1:0] prot_ro_o,        // Read-only settings
	output logic [N_PROT-1:0] prot_xo_o,        // Execute-only settings
	output logic viol_o,                        // Sticky violation flag
	input wire logic viol_clr_i                 // Clear the violation flag
);

	////////////////////////////////////////////////////////////////////////////
	// Storage and state

	logic [DATA_W-1:0] mem [N_ERASE*UNIT_WORDS];

	typedef struct packed {
		state_t st;
		logic [ERASE_IDX_W-1:0] er_unit;
		logic [UNIT_WORD_W-1:0] er_word;
		logic [N_PROT-1:0] ro;
		logic [N_PROT-1:0] xo;
		logic viol;
		logic rsp_valid;
		logic rsp_denied;
		logic [DATA_W-1:0] rdata;
	} regs_t;

	regs_t r;
	regs_t next_r;
	logic mem_we;
	logic [WORD_W-1:0] mem_waddr;
	logic [DATA_W-1:0] mem_wdata;

	// Decode used by both the check and the assertions
	function automatic logic [PROT_IDX_W-1:0] prot_idx(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:PROT_UNIT_SH];
	endfunction : prot_idx

	// Refusal decision for one request against current settings
	function automatic logic refuse(input logic [1:0] op, input logic [1:0] src,
			input logic ro, input logic xo);
		logic modify;
		modify = (op == OP_PROG) || (op == OP_ERASE);
		// Code 3 reads like a plain read, so it must meet the same fetch-only check
		return (modify && (ro || xo)) || (!modify && xo && (src != SRC_FETCH));
	endfunction : refuse

	logic [PROT_IDX_W-1:0] pidx;
	logic deny;
	assign pidx = prot_idx(req_addr_i);
	assign deny = refuse(req_op_i, req_src_i, r.ro[pidx], r.xo[pidx]);

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_r = r;
		next_r.rsp_valid = 1'b0;
		next_r.rsp_denied = 1'b0;
		mem_we = 1'b0;
		mem_waddr = '0;
		mem_wdata = ERASED_WORD;
		if (cfg_we_i) begin
			next_r.ro[cfg_idx_i] = cfg_ro_i;
			next_r.xo[cfg_idx_i] = cfg_xo_i;
		end
		// Clear first so a same-cycle violation still sets the flag
		if (viol_clr_i) begin
			next_r.viol = 1'b0;
		end
		unique case (r.st)
			ST_IDLE: begin
				if (req_valid_i) begin
					if (deny) begin
						next_r.viol = 1'b1;
						next_r.rsp_valid = 1'b1;
						next_r.rsp_denied = 1'b1;
						next_r.rdata = '0;
					end else if (req_op_i == OP_ERASE) begin
						next_r.st = ST_ERASE;
						next_r.er_unit = req_addr_i[ADDR_W-1:ERASE_UNIT_SH];
						next_r.er_word = '0;
					end else if (req_op_i == OP_PROG) begin
						// Program clears bits only, as flash cells do
						mem_we = 1'b1;
						mem_waddr = req_addr_i[ADDR_W-1:2];
						mem_wdata = mem[req_addr_i[ADDR_W-1:2]] & req_wdata_i;
						next_r.rsp_valid = 1'b1;
					end else begin
						next_r.rdata = mem[req_addr_i[ADDR_W-1:2]];
						next_r.rsp_valid = 1'b1;
					end
				end
			end
			ST_ERASE: begin
				mem_we = 1'b1;
				mem_waddr = {r.er_unit, r.er_word};
				mem_wdata = ERASED_WORD;
				next_r.er_word = r.er_word + 1'b1;
				if (r.er_word == UNIT_WORD_W'(UNIT_WORDS - 1)) begin
					next_r.st = ST_IDLE;
					next_r.rsp_valid = 1'b1;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers; array holds no reset, as real flash keeps its contents

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			r.st <= ST_IDLE;
			r.er_unit <= '0;
			r.er_word <= '0;
			r.ro <= RO_RESET;
			r.xo <= XO_RESET;
			r.viol <= 1'b0;
			r.rsp_valid <= 1'b0;
			r.rsp_denied <= 1'b0;
			r.rdata <= '0;
		end else begin
			r <= next_r;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (mem_we) begin
			mem[mem_waddr] <= mem_wdata;
		end
	end

	assign req_ready_o = (r.st == ST_IDLE);
	assign rsp_valid_o = r.rsp_valid;
	assign rsp_denied_o = r.rsp_denied;
	assign rsp_rdata_o = r.rdata;
	assign prot_ro_o = r.ro;
	assign prot_xo_o = r.xo;
	assign viol_o = r.viol;

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	property p_ro_refuse;
		@(posedge clk_sys_i) disable iff (srst_i)
		(req_valid_i && req_ready_o && r.ro[pidx]
			&& (req_op_i == OP_PROG || req_op_i == OP_ERASE))
			|=> (rsp_denied_o && viol_o && r.st == ST_IDLE);
	endproperty
	a_ro_refuse: assert property (p_ro_refuse) else $error("read-only pair modified");

	property p_xo_refuse;
		@(posedge clk_sys_i) disable iff (srst_i)
		// A following request may write, so check that no erase was started instead
		(req_valid_i && req_ready_o && r.xo[pidx]
			&& (req_op_i == OP_PROG || req_op_i == OP_ERASE))
			|=> (rsp_valid_o && rsp_denied_o && r.st == ST_IDLE);
	endproperty
	a_xo_refuse: assert property (p_xo_refuse) else $error("execute-only pair erased");

	property p_xo_read;
		@(posedge clk_sys_i) disable iff (srst_i)
		(req_valid_i && req_ready_o && r.xo[pidx] && req_op_i == OP_READ
			&& req_src_i != SRC_FETCH) |=> (rsp_rdata_o == '0 && rsp_denied_o);
	endproperty
	a_xo_read: assert property (p_xo_read) else $error("execute-only data leaked");

	property p_fetch_ok;
		@(posedge clk_sys_i) disable iff (srst_i)
		(req_valid_i && req_ready_o && req_op_i == OP_READ && req_src_i == SRC_FETCH)
			|=> (rsp_valid_o && !rsp_denied_o);
	endproperty
	a_fetch_ok: assert property (p_fetch_ok) else $error("fetch wrongly refused");

	property p_viol_sticky;
		@(posedge clk_sys_i) disable iff (srst_i)
		(viol_o && !viol_clr_i) |=> viol_o;
	endproperty
	a_viol_sticky: assert property (p_viol_sticky) else $error("violation flag lost");

	property p_erase_len;
		@(posedge clk_sys_i) disable iff (srst_i)
		(req_valid_i && req_ready_o && req_op_i == OP_ERASE && !deny)
			|=> (!req_ready_o && mem_we && mem_wdata == ERASED_WORD)
			##255 (!req_ready_o && !rsp_valid_o)
			##1 (rsp_valid_o && req_ready_o && !rsp_denied_o);
	endproperty
	a_erase_len: assert property (p_erase_len) else $error("erase length wrong");

	property p_erase_ones;
		@(posedge clk_sys_i) disable iff (srst_i)
		(r.st == ST_ERASE) |-> (mem_we && mem_wdata == ERASED_WORD
			&& mem_waddr[WORD_W-1:UNIT_WORD_W] == r.er_unit);
	endproperty
	a_erase_ones: assert property (p_erase_ones) else $error("erase wrote non-ones");

	property p_pair_share;
		@(posedge clk_sys_i) disable iff (srst_i)
		cfg_we_i |=> (prot_ro_o[$past(cfg_idx_i)] == $past(cfg_ro_i)
			&& prot_xo_o[$past(cfg_idx_i)] == $past(cfg_xo_i));
	endproperty
	a_pair_share: assert property (p_pair_share) else $error("pair setting not stored");

	property p_viol_set;
		@(posedge clk_sys_i) disable iff (srst_i)
		(req_valid_i && req_ready_o && deny)
			|=> (viol_o && rsp_valid_o && rsp_denied_o && rsp_rdata_o == '0);
	endproperty
	a_viol_set: assert property (p_viol_set) else $error("refusal not flagged");

endmodule : flash_block_protection
`default_nettype wire

// >>> testbench/req_model.sv
// Requester model for the fetch, data and debug masters on one port
`timescale 1ns/1ps
`default_nettype none
module req_model (
	input wire logic clk_i, // System clock
	input wire logic rdy_i, // Able to take a request
	input wire logic rsp_i, // Request finished
	input wire logic den_i, // Request refused
	input wire logic [31:0] rd_i, // Read data
	output logic val_o, // Request strobe
	output logic [1:0] op_o, // Operation
	output logic [1:0] src_o, // Requester
	output logic [17:0] addr_o, // Byte address
	output logic [31:0] wd_o // Program data
);
	initial begin
		val_o = 1'b0;
		op_o = 2'h0;
		src_o = 2'h0;
		addr_o = 18'h00000;
		wd_o = 32'h00000000;
	end
	//////////////////////////////////////////////////////////////////
	// Held until seen ready, so a request never falls into a busy erase
	task automatic xfer(input logic [1:0] op, input logic [1:0] src, input logic [17:0] a,
		input logic [31:0] wd, output logic den, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk_i);
		val_o <= 1'b1;
		op_o <= op;
		src_o <= src;
		addr_o <= a;
		wd_o <= wd;
		do begin
			@(posedge clk_i);
		end while (rdy_i !== 1'b1);
		val_o <= 1'b0;
		wd_o <= ~wd; // Stale data must not look valid
		// Erase needs 257 cycles, so 300 bounds every wait
		do begin
			@(negedge clk_i);
			n++;
		end while (rsp_i !== 1'b1 && n < 300);
		den = (n < 300) ? den_i : 1'bx;
		rd = rd_i;
	endtask : xfer
endmodule : req_model
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the flash block protection logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import flash_prot_pkg::*;
	logic clk = 1'b0, srst = 1'b1, we = 1'b0, ro = 1'b0, xo = 1'b0, vclr = 1'b0;
	logic [PROT_IDX_W-1:0] idx = '0;
	logic val, rdy, rsp, den, viol;
	logic [1:0] op, src;
	logic [17:0] addr;
	logic [31:0] wd, rd;
	logic [127:0] pro, pxo;
	int bad_count = 0, check_count = 0, cycles = 0;
	always #10 clk = ~clk;
	flash_block_protection flash_block_protection_i (.clk_sys_i(clk), .srst_i(srst),
		.req_valid_i(val), .req_op_i(op), .req_src_i(src), .req_addr_i(addr),
		.req_wdata_i(wd), .req_ready_o(rdy), .rsp_valid_o(rsp), .rsp_denied_o(den),
		.rsp_rdata_o(rd), .cfg_we_i(we), .cfg_idx_i(idx), .cfg_ro_i(ro), .cfg_xo_i(xo),
		.prot_ro_o(pro), .prot_xo_o(pxo), .viol_o(viol), .viol_clr_i(vclr));
	req_model req_model_i (.clk_i(clk), .rdy_i(rdy), .rsp_i(rsp), .den_i(den), .rd_i(rd), .val_o(val),
		.op_o(op), .src_o(src), .addr_o(addr), .wd_o(wd));
	//////////////////////////////////////////////////////////////////
	task automatic results();
		if (bad_count == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results
	// Run takes about 830 cycles; the ceiling leaves wide margin
	always @(posedge clk) begin
		cycles++;
		if (cycles == 10000) begin
			bad_count++;
			$display("Error %0t run timed out", $time);
			results();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Read data is judged only where it is defined: reads and refusals
	task automatic go(input op_t o, input src_t s, input logic [17:0] a, input logic [31:0] w,
		input logic ed, input logic [31:0] er);
		logic d;
		logic [31:0] r;
		req_model_i.xfer(o, s, a, w, d, r);
		chk({31'h0, d}, {31'h0, ed});
		if (o == OP_READ || ed) chk(r, er);
	endtask : go
	task automatic cfg(input logic [6:0] i, input logic r, input logic x);
		@(posedge clk);
		we <= 1'b1;
		idx <= i;
		ro <= r;
		xo <= x;
		@(posedge clk);
		we <= 1'b0;
		@(negedge clk);
		chk({30'h0, pro[i], pxo[i]}, {30'h0, r, x});
	endtask : cfg
	//////////////////////////////////////////////////////////////////
	task automatic t_erase();
		go(OP_ERASE, SRC_DATA, 18'h01000, 32'h0, 1'b0, 32'h0);
		go(OP_PROG, SRC_DATA, 18'h01004, 32'h12345678, 1'b0, 32'h0);
		go(OP_ERASE, SRC_DATA, 18'h00C00, 32'h0, 1'b0, 32'h0);
		go(OP_READ, SRC_DATA, 18'h00C00, 32'h0, 1'b0, ERASED_WORD);
		go(OP_READ, SRC_DATA, 18'h00FFC, 32'h0, 1'b0, ERASED_WORD);
		go(OP_READ, SRC_DATA, 18'h01004, 32'h0, 1'b0, 32'h12345678);
		go(OP_ERASE, SRC_DATA, 18'h01400, 32'h0, 1'b0, 32'h0);
	endtask : t_erase
	task automatic t_ro();
		cfg(7'h02, 1'b1, 1'b0);
		go(OP_PROG, SRC_DATA, 18'h01004, 32'h0, 1'b1, 32'h0);
		chk({31'h0, viol}, 32'h1);
		go(OP_ERASE, SRC_DEBUG, 18'h01400, 32'h0, 1'b1, 32'h0);
		go(OP_READ, SRC_DATA, 18'h01004, 32'h0, 1'b0, 32'h12345678);
		go(OP_READ, SRC_DEBUG, 18'h01400, 32'h0, 1'b0, ERASED_WORD);
		go(OP_PROG, SRC_DATA, 18'h00C00, 32'h0000FFFF, 1'b0, 32'h0);
		go(OP_READ, SRC_DATA, 18'h00C00, 32'h0, 1'b0, 32'h0000FFFF);
		@(posedge clk);
		vclr <= 1'b1;
		@(posedge clk);
		vclr <= 1'b0;
		@(negedge clk);
		chk({31'h0, viol}, 32'h0);
	endtask : t_ro
	task automatic t_xo();
		cfg(7'h02, 1'b0, 1'b1);
		go(OP_READ, SRC_FETCH, 18'h01004, 32'h0, 1'b0, 32'h12345678);
		go(OP_READ, SRC_DATA, 18'h01004, 32'h0, 1'b1, 32'h0);
		go(OP_READ, SRC_DEBUG, 18'h01004, 32'h0, 1'b1, 32'h0);
		go(op_t'(2'h3), SRC_DATA, 18'h01004, 32'h0, 1'b1, 32'h0);
		go(OP_PROG, SRC_FETCH, 18'h01004, 32'h0, 1'b1, 32'h0);
		go(OP_ERASE, SRC_FETCH, 18'h01000, 32'h0, 1'b1, 32'h0);
		go(OP_READ, SRC_FETCH, 18'h01004, 32'h0, 1'b0, 32'h12345678);
		chk({31'h0, viol}, 32'h1);
	endtask : t_xo
	initial begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		chk({30'h0, viol, rdy}, 32'h1);
		t_erase();
		t_ro();
		t_xo();
		results();
	end
endmodule : testbench
`default_nettype wire
